// *** hw/cags_map.svh ***
/*
  Address, vector and timing constants for the CPU address generator and
  special-operation sequencer.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef CAGS_MAP_SVH
`define CAGS_MAP_SVH

`define CAGS_DIRECT_PAGE_HI   8'h00
`define CAGS_POSTINC_STEP     16'h0001
`define CAGS_RESET_VEC_HI     16'hFFFE
`define CAGS_RESET_VEC_LO     16'hFFFF
`define CAGS_QUEUE_FILL_BYTES 2'h3
`define CAGS_FLAG_MASK_BIT    3
`define CAGS_ZERO_BYTE        8'h00
`define CAGS_ONE_BYTE         16'h0001

`endif

// *** hw/cags_pkg.sv ***
/*
  Types shared by the address generator and the special-operation sequencer.
  Assumes the map header is included where constants are needed.
*/
package cags_pkg;

  typedef enum logic [2:0] {
    CAGS_AM_DIRECT,
    CAGS_AM_FULL,
    CAGS_AM_IDX_PLAIN,
    CAGS_AM_IDX_BYTE,
    CAGS_AM_IDX_WORD,
    CAGS_AM_STK_BYTE,
    CAGS_AM_STK_WORD
  } cags_mode_type;

  // one addressing request from the decoder
  typedef struct packed {
    cags_mode_type mode;
    logic          postinc;
    logic [15:0]   operand;
    logic [15:0]   index_pair;
    logic [15:0]   stack_ptr;
  } cags_ea_req_type;

  // one memory bus cycle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cags_bus_type;

  // cpu registers pushed on interrupt entry
  typedef struct packed {
    logic [15:0] prog_counter;
    logic [7:0]  index_low;
    logic [7:0]  accum;
    logic [7:0]  condition_flags_register;
  } cags_context_type;

endpackage

// *** hw/cags_addr_gen.sv ***
/*
  Effective address former for all memory addressing modes.
  Assumes the decoder has assembled extended operands high byte first.
*/
`timescale 1ns/1ns
`include "cags_map.svh"

module cags_addr_gen
  import cags_pkg::*;
(
  input  wire logic            clk,       // bus clock
  input  wire logic            rstn,      // async reset, active low
  input  wire cags_ea_req_type req,       // mode and operands
  input  wire logic            req_valid, // request strobe
  input  wire logic            fetched,   // operand fetch done
  output logic [15:0]          ea_q,      // registered operand address
  output logic                 ea_valid_q,// address valid pulse
  output logic [15:0]          index_next,// index pair after post-inc
  output logic                 index_upd  // index pair update strobe
);

  logic [15:0] ea_d;
  logic [15:0] base;
  logic [15:0] offs;
  logic        pinc_q;
  logic        pinc_d;
  logic [15:0] pidx_q;
  logic [15:0] pidx_d;

  // -------------------------------------------------------------
  // address sums, all wrapping in 64 K
  // -------------------------------------------------------------
  always_comb begin
    base = req.index_pair;
    offs = 16'h0000;
    ea_d = 16'h0000;
    case (req.mode)
      CAGS_AM_DIRECT:    ea_d = {`CAGS_DIRECT_PAGE_HI, req.operand[7:0]};
      CAGS_AM_FULL:      ea_d = req.operand;
      CAGS_AM_IDX_PLAIN: ea_d = req.index_pair;
      CAGS_AM_IDX_BYTE: begin
        offs = {`CAGS_ZERO_BYTE, req.operand[7:0]};
        ea_d = base + offs;
      end
      CAGS_AM_IDX_WORD:  ea_d = req.index_pair + req.operand;
      CAGS_AM_STK_BYTE: begin
        base = req.stack_ptr;
        offs = {`CAGS_ZERO_BYTE, req.operand[7:0]};
        ea_d = base + offs;
      end
      CAGS_AM_STK_WORD:  ea_d = req.stack_ptr + req.operand;
      default:           ea_d = req.operand;
    endcase
  end

  // -------------------------------------------------------------
  // post-increment armed until operand fetch completes
  // -------------------------------------------------------------
  always_comb begin
    pinc_d = pinc_q;
    pidx_d = pidx_q;
    if (req_valid) begin
      // only plain and byte-offset index modes may post-increment
      pinc_d = req.postinc && (req.mode == CAGS_AM_IDX_PLAIN || req.mode == CAGS_AM_IDX_BYTE);
      pidx_d = req.index_pair;
    end else if (fetched) begin
      pinc_d = 1'b0;
    end
  end

  assign index_next = pidx_q + `CAGS_POSTINC_STEP;
  assign index_upd  = pinc_q && fetched && !req_valid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ea_q       <= 16'h0000;
      ea_valid_q <= 1'b0;
      pinc_q     <= 1'b0;
      pidx_q     <= 16'h0000;
    end else begin
      ea_q       <= req_valid ? ea_d : ea_q;
      ea_valid_q <= req_valid;
      pinc_q     <= pinc_d;
      pidx_q     <= pidx_d;
    end
  end

endmodule

// *** hw/cags_top.sv ***
/*
  CPU address generation and special-operation sequencer: reset vector fetch,
  interrupt entry and software trap, wait and stop with debug wake.
  Assumes a single-cycle memory bus and that reset sources, the debug pin and
  wake lines are asynchronous to clk; instruction decoding lives elsewhere.
*/
`timescale 1ns/1ns
`include "cags_map.svh"

module cags_top
  import cags_pkg::*;
#(
  parameter int VEC_W = 16                      // vector address width
)(
  input  wire logic             clk,            // bus clock 25 MHz
  input  wire logic             rstn,           // power-on/pin reset, active low
  input  wire logic             watchdog_reset_source, // watchdog reset request
  input  wire logic             rst_src_done,   // internal source check done
  input  wire cags_ea_req_type  ea_req,         // addressing request
  input  wire logic             ea_req_valid,   // addressing request strobe
  input  wire logic             op_fetched,     // operand fetch complete
  input  wire logic             insn_boundary,  // current instruction ending
  input  wire logic             insn_cleared_mask, // instruction cleared mask
  input  wire logic             trap_req,       // software trap opcode
  input  wire logic             wait_req,       // wait opcode
  input  wire logic             stop_req,       // stop opcode
  input  wire logic             irq_pending,    // maskable request pending
  input  wire logic [VEC_W-1:0] irq_vector,     // highest priority vector addr
  input  wire logic [VEC_W-1:0] trap_vector,    // trap vector address
  input  wire cags_context_type ctx,            // registers to push
  input  wire logic [15:0]      stack_ptr,      // current stack pointer
  input  wire logic [7:0]       rdata,          // memory read data
  input  wire logic             debug_halt_cmd, // halt-to-background command
  input  wire logic             debug_mode_enable, // debug enable bit
  input  wire logic             stop_clk_keep,  // keep minimal clocks in stop
  input  wire logic             periodic_wake,  // internal periodic wake
  input  wire logic             ext_wake,       // external wake line
  output cags_bus_type          bus_q,          // memory bus cycle
  output logic [15:0]           ea_q,           // effective address
  output logic                  ea_valid_q,     // effective address valid
  output logic [15:0]           index_next,     // post-incremented index
  output logic                  index_upd,      // index update strobe
  output logic [15:0]           new_pc_q,       // vector loaded into PC
  output logic                  new_pc_valid_q, // PC load pulse
  output logic [7:0]            queue_byte_q,   // instruction queue fill byte
  output logic                  queue_load_q,   // queue byte strobe
  output logic                  mask_set_q,     // interrupt mask set pulse
  output logic                  mask_clr_q,     // interrupt mask clear pulse
  output logic [15:0]           stack_ptr_q,    // stack pointer after push
  output logic                  cpu_clk_en_q,   // cpu clock gate enable
  output logic                  osc_keep_q,     // oscillator kept in stop
  output logic                  stop_clk_min_q, // minimal clocks running
  output logic                  background_q,   // active background mode
  output logic                  seq_busy        // special sequence running
);

  typedef enum logic [3:0] {
    ST_RESET, ST_RVEC_HI, ST_RVEC_LO, ST_FREE, ST_QFILL, ST_RUN,
    ST_PUSH, ST_MASK, ST_VEC_HI, ST_VEC_LO, ST_WAIT, ST_STOP, ST_BGND
  } cags_state_type;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] pins;
  assign pins = {watchdog_reset_source, rst_src_done, debug_halt_cmd,
                 periodic_wake, ext_wake, irq_pending};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic wdog_s, srcdone_s, halt_s, pwake_s, xwake_s, irq_s;
  assign {wdog_s, srcdone_s, halt_s, pwake_s, xwake_s, irq_s} = sync2_q;

  // -------------------------------------------------------------
  // address former
  // -------------------------------------------------------------
  cags_addr_gen u_ea (
    .clk        (clk),
    .rstn       (rstn),
    .req        (ea_req),
    .req_valid  (ea_req_valid),
    .fetched    (op_fetched),
    .ea_q       (ea_q),
    .ea_valid_q (ea_valid_q),
    .index_next (index_next),
    .index_upd  (index_upd)
  );

  // -------------------------------------------------------------
  // sequencer state
  // -------------------------------------------------------------
  cags_state_type   st_q, st_d;
  logic [2:0]       cnt_q, cnt_d;
  logic [15:0]      vec_q, vec_d;
  logic [15:0]      pc_q, pc_d;
  logic [15:0]      sp_q, sp_d;
  logic [15:0]      vaddr_q, vaddr_d;
  cags_context_type ctx_q, ctx_d;
  cags_bus_type     bus_d;
  logic [7:0]       qbyte_d;
  logic             qload_d, mset_d, mclr_d, pcv_d, clken_d, osc_d, smin_d, bg_d;
  logic             irq_take;

  // take only at boundary, not after mask clear
  // the boundary that ends a mask-clearing instruction is the one refused,
  // so the flag is used in the same cycle; no state is kept past it
  assign irq_take = irq_s && insn_boundary && !insn_cleared_mask
                    && !ctx.condition_flags_register[`CAGS_FLAG_MASK_BIT];
  assign seq_busy = (st_q != ST_RUN);

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    vec_d     = vec_q;
    pc_d      = pc_q;
    sp_d      = sp_q;
    vaddr_d   = vaddr_q;
    ctx_d     = ctx_q;
    bus_d     = '0;
    qbyte_d   = queue_byte_q;
    qload_d   = 1'b0;
    mset_d    = 1'b0;
    mclr_d    = 1'b0;
    pcv_d     = 1'b0;
    clken_d   = cpu_clk_en_q;
    osc_d     = osc_keep_q;
    smin_d    = stop_clk_min_q;
    bg_d      = background_q;
    case (st_q)
      ST_RESET: begin
        clken_d = 1'b1;
        if (srcdone_s) begin
          st_d       = ST_RVEC_HI;
          bus_d.valid = 1'b1;
          bus_d.addr  = `CAGS_RESET_VEC_HI;
        end
      end
      // six cycles: two vector, free, three fill
      ST_RVEC_HI: begin
        vec_d[15:8] = rdata;
        st_d        = ST_RVEC_LO;
        bus_d.valid = 1'b1;
        bus_d.addr  = `CAGS_RESET_VEC_LO;
      end
      ST_RVEC_LO, ST_VEC_LO: begin
        vec_d[7:0] = rdata;
        st_d       = ST_FREE;
      end
      ST_FREE: begin
        pc_d    = vec_q;
        pcv_d   = 1'b1;
        cnt_d   = 3'h0;
        st_d    = ST_QFILL;
        bus_d.valid = 1'b1;
        bus_d.addr  = vec_q;
      end
      ST_QFILL: begin
        qbyte_d = rdata;
        qload_d = 1'b1;
        cnt_d   = cnt_q + 3'h1;
        if (cnt_q == 3'({1'b0, `CAGS_QUEUE_FILL_BYTES}) - 3'h1) begin
          st_d = ST_RUN;
        end else begin
          bus_d.valid = 1'b1;
          bus_d.addr  = vec_q + 16'(cnt_q) + `CAGS_ONE_BYTE;
        end
      end
      ST_RUN: begin
        if (halt_s) begin
          st_d = ST_BGND;
        end else if (trap_req || irq_take) begin
          vaddr_d = trap_req ? 16'(trap_vector) : 16'(irq_vector);
          ctx_d   = ctx;
          sp_d    = stack_ptr;
          cnt_d   = 3'h0;
          st_d    = ST_PUSH;
        end else if (wait_req) begin
          mclr_d  = 1'b1;
          clken_d = 1'b0;
          st_d    = ST_WAIT;
        end else if (stop_req) begin
          clken_d = 1'b0;
          osc_d   = debug_mode_enable;
          smin_d  = stop_clk_keep;
          st_d    = ST_STOP;
        end
      end
      ST_PUSH: begin
        bus_d.valid = 1'b1;
        bus_d.write = 1'b1;
        bus_d.addr  = sp_q;
        case (cnt_q)
          3'h0:    bus_d.wdata = ctx_q.prog_counter[7:0];
          3'h1:    bus_d.wdata = ctx_q.prog_counter[15:8];
          3'h2:    bus_d.wdata = ctx_q.index_low;
          3'h3:    bus_d.wdata = ctx_q.accum;
          default: bus_d.wdata = ctx_q.condition_flags_register;
        endcase
        sp_d  = sp_q - `CAGS_ONE_BYTE;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h4) begin
          st_d = ST_MASK;
        end
      end
      ST_MASK: begin
        mset_d      = 1'b1;
        st_d        = ST_VEC_HI;
        bus_d.valid = 1'b1;
        bus_d.addr  = vaddr_q;
      end
      ST_VEC_HI: begin
        st_d        = ST_VEC_LO;
        bus_d.valid = 1'b1;
        bus_d.addr  = vaddr_q + `CAGS_ONE_BYTE;
        vec_d[15:8] = rdata;
      end
      ST_WAIT: begin
        if (halt_s) begin
          clken_d = 1'b1;
          bg_d    = 1'b1;
          st_d    = ST_BGND;
        end else if (irq_s) begin
          clken_d = 1'b1;
          st_d    = ST_RUN;
        end
      end
      ST_STOP: begin
        if (halt_s && osc_keep_q) begin
          clken_d = 1'b1;
          bg_d    = 1'b1;
          osc_d   = 1'b0;
          smin_d  = 1'b0;
          st_d    = ST_BGND;
        // periodic wake only with minimal clocks
        end else if (xwake_s || irq_s || (pwake_s && stop_clk_min_q)) begin
          clken_d = 1'b1;
          osc_d   = 1'b0;
          smin_d  = 1'b0;
          st_d    = ST_RUN;
        end
      end
      ST_BGND: begin
        clken_d = 1'b1;
        bg_d    = 1'b1;
      end
      default: st_d = ST_RESET;
    endcase
    if (wdog_s) begin
      st_d    = ST_RESET;
      bus_d   = '0;
      qload_d = 1'b0;
      pcv_d   = 1'b0;
      bg_d    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q           <= ST_RESET;
      cnt_q          <= 3'h0;
      vec_q          <= 16'h0000;
      pc_q           <= 16'h0000;
      sp_q           <= 16'h0000;
      vaddr_q        <= 16'h0000;
      ctx_q          <= '0;
      bus_q          <= '0;
      queue_byte_q   <= 8'h00;
      queue_load_q   <= 1'b0;
      mask_set_q     <= 1'b0;
      mask_clr_q     <= 1'b0;
      new_pc_valid_q <= 1'b0;
      cpu_clk_en_q   <= 1'b1;
      osc_keep_q     <= 1'b0;
      stop_clk_min_q <= 1'b0;
      background_q   <= 1'b0;
    end else begin
      st_q           <= st_d;
      cnt_q          <= cnt_d;
      vec_q          <= vec_d;
      pc_q           <= pc_d;
      sp_q           <= sp_d;
      vaddr_q        <= vaddr_d;
      ctx_q          <= ctx_d;
      bus_q          <= bus_d;
      queue_byte_q   <= qbyte_d;
      queue_load_q   <= qload_d;
      mask_set_q     <= mset_d;
      mask_clr_q     <= mclr_d;
      new_pc_valid_q <= pcv_d;
      cpu_clk_en_q   <= clken_d;
      osc_keep_q     <= osc_d;
      stop_clk_min_q <= smin_d;
      background_q   <= bg_d;
    end
  end

  assign new_pc_q    = pc_q;
  assign stack_ptr_q = sp_q;

endmodule

// *** verification/cags_top_assertions.sv ***
/*
  Port checks for the address and sequencer top.
  Assumes one clock, async low reset and ctx held steady during entry.
*/
`timescale 1ns/1ns
module cags_top_assertions
  import cags_pkg::*;
(
  input wire logic            clk,          // bus clock
  input wire logic            rstn,         // async reset
  input wire cags_ea_req_type ea_req,       // address request
  input wire logic            ea_req_valid, // request strobe
  input wire logic            wait_req,     // wait opcode
  input wire logic            seq_busy,     // sequence running
  input wire cags_context_type ctx,         // pushed registers
  input wire cags_bus_type    bus_q,        // memory cycle
  input wire logic [15:0]     ea_q,         // effective address
  input wire logic            ea_valid_q,   // address valid
  input wire logic [15:0]     index_next,   // incremented index
  input wire logic            index_upd,    // index strobe
  input wire logic            mask_set_q,   // mask set pulse
  input wire logic            cpu_clk_en_q, // clock gate
  input wire logic            background_q  // background mode
);
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  logic        wr;
  logic        rd;
  logic [15:0] idx_q;
  logic [15:0] idx_d;
  assign wr = bus_q.valid & bus_q.write;
  assign rd = bus_q.valid & ~bus_q.write;
  // index seen at the request, for the increment check
  always_comb idx_d = ea_req_valid ? ea_req.index_pair : idx_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idx_q <= 16'h0000;
    else idx_q <= idx_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_push;
    bus_q.wdata == ctx.prog_counter[7:0] ##1 wr && bus_q.wdata == ctx.prog_counter[15:8]
    ##1 wr && bus_q.wdata == ctx.index_low ##1 wr && bus_q.wdata == ctx.accum
    ##1 wr && bus_q.wdata == ctx.condition_flags_register && bus_q.addr == $past(bus_q.addr) - 16'h0001;
  endsequence
  sequence s_vector;
    ##5 (mask_set_q && rd) ##1 rd ##1 !bus_q.valid ##1 rd;
  endsequence
  chk_direct_page: assert property (
    ea_req_valid && ea_req.mode == CAGS_AM_DIRECT |=> ea_valid_q && ea_q == {8'h00, $past(ea_req.operand[7:0])})
    else $error("direct address wrong");
  chk_index_byte: assert property (
    ea_req_valid && ea_req.mode == CAGS_AM_IDX_BYTE |=>
    ea_q == $past(ea_req.index_pair) + $past(ea_req.operand[7:0])) else $error("indexed byte address wrong");
  chk_stack_word: assert property (
    ea_req_valid && ea_req.mode == CAGS_AM_STK_WORD |=>
    ea_q == $past(ea_req.stack_ptr) + $past(ea_req.operand)) else $error("stack word address wrong");
  chk_postinc_step: assert property (
    index_upd |-> index_next == idx_q + 16'h0001) else $error("post increment wrong");
  chk_reset_vector: assert property (
    rd && bus_q.addr == 16'hFFFE |=> rd && bus_q.addr == 16'hFFFF ##1 !bus_q.valid) else $error("reset vector order");
  chk_push_order: assert property (
    wr && !$past(wr) |-> s_push) else $error("push order wrong");
  chk_mask_vector: assert property (
    wr && !$past(wr) |-> s_vector) else $error("entry tail wrong");
  chk_wait_gate: assert property (
    wait_req && !seq_busy |-> ##[1:4] !cpu_clk_en_q) else $error("wait kept clocks");
  chk_bg_clock: assert property (
    $rose(background_q) |-> cpu_clk_en_q) else $error("background without clocks");
endmodule
bind cags_top cags_top_assertions cags_top_assertions_i (.clk, .rstn, .ea_req, .ea_req_valid, .wait_req, .seq_busy,
  .ctx, .bus_q, .ea_q, .ea_valid_q, .index_next, .index_upd, .mask_set_q, .cpu_clk_en_q, .background_q);

// *** verification/cags_mem_model.sv ***
/*
  Memory and debug host partner for the sequencer top.
  Assumes reads answer within the cycle in which bus_q shows the read.
*/
`timescale 1ns/1ns
module cags_mem_model
  import cags_pkg::*;
(
  input wire logic         clk,           // bus clock
  input wire logic         rstn,          // async reset
  input wire cags_bus_type bus_q,         // memory cycle
  input wire logic         halt_go,       // bench asks for halt
  input wire logic         background_q,  // background mode
  output logic [7:0]       rdata,         // read data
  output logic             debug_halt_cmd // halt command level
);
  // ----------------------------------------
  // memory and host
  // ----------------------------------------
  // idle cycles show the previous cycle's data inverted, so a stale byte returns every second idle cycle
  logic [7:0] last_q;
  always_comb rdata = (bus_q.valid && !bus_q.write) ? (bus_q.addr[7:0] ^ 8'h5A) : ~last_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) last_q <= 8'h00;
    else last_q <= rdata;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) debug_halt_cmd <= 1'b0;
    else if (background_q) debug_halt_cmd <= 1'b0;
    else if (halt_go) debug_halt_cmd <= 1'b1;
  end
endmodule

// *** verification/tb_cags_top.sv ***
/*
  Scenario bench for the sequencer top.
  Assumes the memory partner model and the bound checker.
*/
`timescale 1ns/1ns
module tb_cags_top;
  import cags_pkg::*;
  // ----------------------------------------
  // signals, instances, scenarios
  // ----------------------------------------
  logic clk, rstn, rst_src_done, ea_req_valid, op_fetched, insn_boundary, insn_cleared_mask, halt_go;
  logic trap_req, wait_req, stop_req, irq_pending, debug_mode_enable, stop_clk_keep, periodic_wake;
  logic ea_valid_q, index_upd, new_pc_valid_q, queue_load_q, mask_set_q, mask_clr_q, cpu_clk_en_q, osc_keep_q;
  logic stop_clk_min_q, background_q, seq_busy, debug_halt_cmd, wdog;
  logic [15:0] irq_vector, trap_vector, stack_ptr, ea_q, index_next, new_pc_q, stack_ptr_q;
  logic [7:0]  rdata, queue_byte_q;
  cags_ea_req_type  ea_req;
  cags_context_type ctx;
  cags_bus_type     bus_q;
  int          n_fail, samples_checked;
  always #20 clk = ~clk;
  cags_top cags_top_i (.clk, .rstn, .watchdog_reset_source(wdog), .rst_src_done, .ea_req, .ea_req_valid, .op_fetched,
    .insn_boundary, .insn_cleared_mask, .trap_req, .wait_req, .stop_req, .irq_pending, .irq_vector, .trap_vector,
    .ctx, .stack_ptr, .rdata, .debug_halt_cmd, .debug_mode_enable, .stop_clk_keep, .periodic_wake, .ext_wake(1'b0),
    .bus_q, .ea_q, .ea_valid_q, .index_next, .index_upd, .new_pc_q, .new_pc_valid_q, .queue_byte_q, .queue_load_q,
    .mask_set_q, .mask_clr_q, .stack_ptr_q, .cpu_clk_en_q, .osc_keep_q, .stop_clk_min_q, .background_q, .seq_busy);
  cags_mem_model cags_mem_model_i (.clk, .rstn, .bus_q, .halt_go, .background_q, .rdata, .debug_halt_cmd);
  task results;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function logic sig(input int k);
    case (k)
      0: return bus_q.valid & bus_q.write;
      1: return new_pc_valid_q;
      2: return !cpu_clk_en_q;
      3: return background_q;
      4: return osc_keep_q;
      5: return stop_clk_min_q;
      6: return cpu_clk_en_q;
      7: return bus_q.valid & ~bus_q.write;
      8: return !seq_busy;
      9: return queue_load_q;
      default: return mask_clr_q;
    endcase
  endfunction
  // bounded wait, checked before advancing
  task wait_for(input int k);
    int i;
    for (i = 0; i < 300 && sig(k) !== 1'b1; i++) @(negedge clk);
    if (i == 300) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout waiting on %h", $time, k);
      results();
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task quiet;
    repeat (4) begin
      @(negedge clk);
      chk(seq_busy, 0);
    end
  endtask
  function logic [15:0] ea_exp(input cags_mode_type m, input logic [15:0] op, ix, sp);
    case (m)
      CAGS_AM_DIRECT: return {8'h00, op[7:0]};
      CAGS_AM_FULL: return op;
      CAGS_AM_IDX_PLAIN: return ix;
      CAGS_AM_IDX_BYTE: return ix + op[7:0];
      CAGS_AM_IDX_WORD: return ix + op;
      CAGS_AM_STK_BYTE: return sp + op[7:0];
      default: return sp + op;
    endcase
  endfunction
  task do_reset;
    int i;
    @(negedge clk) rstn = 1'b0;
    rst_src_done = 1'b0;
    #1 chk(bus_q.valid, 0);
    chk(background_q, 0);
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (6) begin
      @(negedge clk);
      chk(bus_q.valid, 0);
    end
    rst_src_done = 1'b1;
    wait_for(7);
    chk(bus_q.addr, 16'hFFFE);
    wait_for(1);
    chk(new_pc_q, 16'hA4A5);
    for (i = 0; i < 3; i++) begin
      wait_for(9);
      chk(queue_byte_q, {8'h00, (8'hA5 + 8'(i)) ^ 8'h5A});
      @(negedge clk);
    end
  endtask
  task t_ea;
    logic [15:0] ops [7];
    int i;
    ops = '{16'h12AB, 16'hBEEF, 16'h0000, 16'h0090, 16'h1234, 16'h00F0, 16'h0010};
    ea_req.index_pair = 16'hFFF0;
    ea_req.stack_ptr = 16'hFFF8;
    // back-to-back requests, one per cycle
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      if (i > 0) chk(ea_q, ea_exp(cags_mode_type'(i - 1), ops[i - 1], 16'hFFF0, 16'hFFF8));
      ea_req_valid = (i < 7);
      ea_req.mode = cags_mode_type'(i % 7);
      ea_req.operand = ops[i % 7];
    end
    for (i = 0; i < 2; i++) begin
      @(negedge clk);
      ea_req = '{i ? CAGS_AM_IDX_BYTE : CAGS_AM_IDX_PLAIN, 1'b1, 16'h0005, i ? 16'h0010 : 16'hFFFF, 16'h0000};
      ea_req_valid = 1'b1;
      @(negedge clk) ea_req_valid = 1'b0;
      chk(ea_q, i ? 16'h0015 : 16'hFFFF);
      op_fetched = 1'b1;
      #1 chk(index_upd, 1);
      chk(index_next, i ? 16'h0011 : 16'h0000);
      @(negedge clk) op_fetched = 1'b0;
    end
  endtask
  task entry(input logic [15:0] vec, input logic [15:0] pc_exp);
    logic [7:0] p [5];
    int i;
    p = '{ctx.prog_counter[7:0], ctx.prog_counter[15:8], ctx.index_low, ctx.accum, ctx.condition_flags_register};
    wait_for(0);
    for (i = 0; i < 5; i++) begin
      chk(bus_q.wdata, p[i]);
      chk(bus_q.addr, stack_ptr - i);
      @(negedge clk);
    end
    chk(mask_set_q, 1);
    chk(bus_q.addr, vec);
    wait_for(1);
    chk(new_pc_q, pc_exp);
    wait_for(8);
  endtask
  task t_irq;
    ctx = '{16'h1234, 8'h56, 8'h78, 8'h08};
    stack_ptr = 16'h01F0;
    irq_vector = 16'h2000;
    irq_pending = 1'b1;
    repeat (3) @(negedge clk);
    pulse(insn_boundary);
    quiet();
    ctx.condition_flags_register = 8'h00;
    quiet();
    insn_cleared_mask = 1'b1;
    pulse(insn_boundary);
    quiet();
    insn_cleared_mask = 1'b0;
    pulse(insn_boundary);
    entry(16'h2000, 16'h5A5B);
    irq_pending = 1'b0;
  endtask
  task t_trap;
    ctx.condition_flags_register = 8'h08;
    trap_vector = 16'h3010;
    pulse(trap_req);
    entry(16'h3010, 16'h4A4B);
  endtask
  task t_low_power;
    pulse(wait_req);
    wait_for(10);
    wait_for(2);
    halt_go = 1'b1;
    wait_for(3);
    chk(cpu_clk_en_q, 1);
    halt_go = 1'b0;
    do_reset();
    debug_mode_enable = 1'b1;
    pulse(stop_req);
    wait_for(4);
    halt_go = 1'b1;
    wait_for(3);
    chk(cpu_clk_en_q, 1);
    halt_go = 1'b0;
    do_reset();
    debug_mode_enable = 1'b0;
    stop_clk_keep = 1'b1;
    pulse(stop_req);
    wait_for(5);
    periodic_wake = 1'b1;
    wait_for(6);
    periodic_wake = 1'b0;
  endtask
  task t_wdog;
    wdog = 1'b1;
    repeat (4) @(negedge clk);
    chk(seq_busy, 1);
    wdog = 1'b0;
    wait_for(7);
    chk(bus_q.addr, 16'hFFFE);
  endtask
  initial begin
    {clk, rstn, rst_src_done, ea_req_valid, op_fetched, insn_boundary, insn_cleared_mask, halt_go, wdog} = '0;
    {trap_req, wait_req, stop_req, irq_pending, debug_mode_enable, stop_clk_keep, periodic_wake} = '0;
    {irq_vector, trap_vector, stack_ptr} = '0;
    ea_req = '0;
    ctx = '0;
    n_fail = 0;
    samples_checked = 0;
    do_reset();
    t_ea();
    t_irq();
    t_trap();
    t_low_power();
    t_wdog();
    results();
  end
endmodule
